// file: tsiu_defs.vh
/*
 constants for the event counter, serial shift port and interrupt collector.
 assumes apb byte addresses are four times the printed register index.
*/
`ifndef TSIU_DEFS_VH
`define TSIU_DEFS_VH
`define TSIU_IDX_CNT_LOW   4'h8
`define TSIU_IDX_CNT_MID   4'h9
`define TSIU_IDX_CNT_HIGH  4'ha
`define TSIU_IDX_CTRL      4'hb
`define TSIU_IDX_SERIAL    4'hc
`define TSIU_IDX_IRQ       4'hd
`define TSIU_IDX_TIMER_CTL 4'he
`define TSIU_CTRL_ALARM_SEL 1
`define TSIU_CTRL_SER_DIR   0
`define TSIU_TCTL_DIVIDER   15:0
`define TSIU_TCTL_START     16
`define TSIU_IRQ_TA     0
`define TSIU_IRQ_TB     1
`define TSIU_IRQ_ALARM  2
`define TSIU_IRQ_SERIAL 3
`define TSIU_IRQ_EDGE   4
`define TSIU_IRQ_SOURCES 5
`define TSIU_IRQ_SUMMARY 7
`define TSIU_IRQ_SETCLR 7
`define TSIU_BIT_COUNT  4'h8
`define TSIU_TDIV_RESET 16'h0001
`endif

// file: tsiu_sync.v
/*
 two flip-flop synchroniser for a single level.
 assumes the input is asynchronous to clk.
*/
module tsiu_sync (
   input  wire clk,
   input  wire rst_n,
   input  wire d,
   output wire q
);
   reg stage1;
   reg stage2;
   // first stage feeds only the second
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
      end else begin
         stage1 <= d;
         stage2 <= stage1;
      end
   end
   assign q = stage2;
endmodule // tsiu_sync

// file: tsiu_top.v
/*
 event counter with alarm, buffered serial shift port and interrupt collector,
 reached over apb. assumes open-drain pins are resolved outside (low when oe).
*/
`include "tsiu_defs.vh"

// How it works
// - 24-bit counter counts event pin rises
// - alarm select bit routes counter writes
// - counter reads never return alarm value
// - counter match raises alarm interrupt
// - mid or high write halts, low write resumes
// - high read freezes copy until low
// - bytes map low, mid, high indices
// - buffered 8-bit shift port, selectable direction
// - receive samples on clock rise, eight
// - transmit at half timer a rate
// - data write in transmit starts shifting
// - bit changes on falling shift clock
// - eight bits interrupt, pending byte continues
// - idle leaves clock high, data held
// - most significant bit first both ways
// - shift clock and data open drain
// - each source sets its flag always
// - masked flag sets summary, request low
// - flag read returns then clears those it returned set
// - mask write sets or clears selected
// - direction bit one transmits, zero receives
// - flag pin falling edge sets flag
module tsiu_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        event_pin,
   input  wire        edge_pin_flag_in,
   input  wire        timer_b_underflow,
   input  wire        shift_clock_pin_in,
   output wire        shift_clock_pin_out,
   output wire        shift_clock_pin_oe,
   input  wire        serial_data_pin_in,
   output wire        serial_data_pin_out,
   output wire        serial_data_pin_oe,
   output wire        irq_n
);
   wire        ev_s;
   wire        edge_s;
   wire        sclk_s;
   wire        sdat_s;
   reg         ev_d;
   reg         edge_d;
   reg         sclk_d;
   reg  [23:0] event_counter;
   reg  [23:0] alarm_value;
   reg  [23:0] read_copy;
   reg         count_run;
   reg         frozen;
   reg         match_d;
   reg  [1:0]  ctrl;
   reg  [16:0] timer_ctl;
   reg  [15:0] timer_cnt;
   reg  [7:0]  serial_buf;
   reg         buf_pending;
   reg  [7:0]  shifter;
   reg  [3:0]  bit_cnt;
   reg         tx_active;
   reg         tx_clk;
   reg         tx_data;
   reg  [4:0]  flags;
   reg  [4:0]  mask;
   reg         timer_a_flag;
   reg         serial_flag;
   wire        wr;
   wire        rd;
   wire [3:0]  idx;
   wire        tx_mode;
   wire        timer_a_uf;
   wire        alarm_flag;
   wire        edge_fall;
   wire        ev_rise;
   wire        sclk_rise;
   wire [4:0]  events;
   wire        request_summary_bit;
   wire        flag_read;
   wire        rd_setup;
   wire        ser_wr;

   // register index decode, shared by reads and writes
   function is_idx;
      input [31:0] a;
      input [3:0]  i;
      begin
         is_idx = (a[31:6] == 26'h0000000) && (a[1:0] == 2'h0) && (a[5:2] == i);
      end
   endfunction

   tsiu_sync u_ev (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (event_pin),
      .q     (ev_s)
   );
   tsiu_sync u_edge (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (edge_pin_flag_in),
      .q     (edge_s)
   );
   tsiu_sync u_sclk (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (shift_clock_pin_in),
      .q     (sclk_s)
   );
   tsiu_sync u_sdat (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (serial_data_pin_in),
      .q     (sdat_s)
   );

   // zero wait states; unmapped reads return zero without error
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr  = psel & penable & pwrite;
   assign rd  = psel & penable & ~pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign ser_wr   = wr & is_idx(paddr, `TSIU_IDX_SERIAL);
   assign idx = paddr[5:2];
   assign tx_mode   = ctrl[`TSIU_CTRL_SER_DIR];
   assign ev_rise   = ev_s & ~ev_d;
   assign edge_fall = edge_d & ~edge_s;
   assign sclk_rise = sclk_s & ~sclk_d;
   assign alarm_flag = (event_counter == alarm_value) & ~match_d;
   assign timer_a_uf = timer_ctl[`TSIU_TCTL_START] & (timer_cnt == 16'h0000);
   assign events = {edge_fall,
                    serial_flag,
                    alarm_flag,
                    timer_b_underflow,
                    timer_a_flag};
   assign request_summary_bit = |(flags & mask);
   assign irq_n = ~request_summary_bit;
   assign flag_read = rd & is_idx(paddr, `TSIU_IDX_IRQ);
   // open drain: only ever pull low
   assign shift_clock_pin_out = 1'b0;
   assign serial_data_pin_out = 1'b0;
   assign shift_clock_pin_oe  = tx_mode & ~tx_clk;
   assign serial_data_pin_oe  = tx_mode & ~tx_data;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // same level as the synchroniser after reset, so no false rise
         ev_d   <= 1'b1;
         edge_d <= 1'b1;
         sclk_d <= 1'b1;
         match_d <= 1'b0;
      end else begin
         ev_d   <= ev_s;
         edge_d <= edge_s;
         sclk_d <= sclk_s;
         match_d <= (event_counter == alarm_value);
      end
   end

   // event counter, alarm and read latch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_counter <= 24'h000000;
         alarm_value   <= 24'hffffff;
         read_copy     <= 24'h000000;
         count_run     <= 1'b0;
         frozen        <= 1'b0;
      end else begin
         if (count_run && ev_rise)
            event_counter <= event_counter + 24'h000001;
         if (wr && ctrl[`TSIU_CTRL_ALARM_SEL]) begin
            if (is_idx(paddr, `TSIU_IDX_CNT_LOW)) begin
               alarm_value[7:0] <= pwdata[7:0];
            end
            if (is_idx(paddr, `TSIU_IDX_CNT_MID)) begin
               alarm_value[15:8] <= pwdata[7:0];
            end
            if (is_idx(paddr, `TSIU_IDX_CNT_HIGH)) begin
               alarm_value[23:16] <= pwdata[7:0];
            end
         end else if (wr) begin
            // a mid or high write stops counting and a low write restarts it, so software starts at a known time
            if (is_idx(paddr, `TSIU_IDX_CNT_LOW)) begin
               event_counter[7:0] <= pwdata[7:0];
               count_run <= 1'b1;
            end
            if (is_idx(paddr, `TSIU_IDX_CNT_MID)) begin
               event_counter[15:8] <= pwdata[7:0];
               count_run <= 1'b0;
            end
            if (is_idx(paddr, `TSIU_IDX_CNT_HIGH)) begin
               event_counter[23:16] <= pwdata[7:0];
               count_run <= 1'b0;
            end
         end
         // the copy stops at the high read's setup, on the value that read returns
         if (!frozen && !(rd_setup && is_idx(paddr, `TSIU_IDX_CNT_HIGH)))
            read_copy <= event_counter;
         if (rd_setup && is_idx(paddr, `TSIU_IDX_CNT_HIGH))
            frozen <= 1'b1;
         else if (rd && is_idx(paddr, `TSIU_IDX_CNT_LOW))
            frozen <= 1'b0;
      end
   end

   // control, timer a stand-in, mask and timer a flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl      <= 2'h0;
         timer_ctl <= {1'b0, `TSIU_TDIV_RESET};
         timer_cnt <= `TSIU_TDIV_RESET;
         timer_a_flag <= 1'b0;
         mask      <= 5'h00;
      end else begin
         if (wr && is_idx(paddr, `TSIU_IDX_CTRL))
            ctrl <= pwdata[1:0];
         if (wr && is_idx(paddr, `TSIU_IDX_TIMER_CTL))
            timer_ctl <= pwdata[16:0];
         // continuous countdown; software must start it before sending
         if (!timer_ctl[`TSIU_TCTL_START] || timer_cnt == 16'h0000)
            timer_cnt <= timer_ctl[`TSIU_TCTL_DIVIDER];
         else
            timer_cnt <= timer_cnt - 16'h0001;
         timer_a_flag <= timer_a_uf;
         if (wr && is_idx(paddr, `TSIU_IDX_IRQ)) begin
            if (pwdata[`TSIU_IRQ_SETCLR])
               mask <= mask | pwdata[4:0];
            else
               mask <= mask & ~pwdata[4:0];
         end
      end
   end

   // one flag per source; an event in the clearing cycle wins, and a flag set
   // after the read data was taken is kept, so no event is lost to the read
   genvar gi;
   generate
      for (gi = 0; gi < `TSIU_IRQ_SOURCES; gi = gi + 1) begin : g_flag
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               flags[gi] <= 1'b0;
            else if (events[gi])
               flags[gi] <= 1'b1;
            else if (flag_read && prdata[gi])
               flags[gi] <= 1'b0;
         end
      end
   endgenerate

   // serial shift port
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_buf  <= 8'h00;
         buf_pending <= 1'b0;
         shifter     <= 8'h00;
         bit_cnt     <= 4'h0;
         tx_active   <= 1'b0;
         tx_clk      <= 1'b1;
         tx_data     <= 1'b1;
         serial_flag <= 1'b0;
      end else begin
         serial_flag <= 1'b0;
         if (wr && is_idx(paddr, `TSIU_IDX_SERIAL)) begin
            serial_buf  <= pwdata[7:0];
            buf_pending <= tx_mode;
         end
         if (!tx_mode) begin
            tx_active <= 1'b0;
            tx_clk    <= 1'b1;
            if (sclk_rise) begin
               shifter <= {shifter[6:0], sdat_s};
               if (bit_cnt == `TSIU_BIT_COUNT - 4'h1) begin
                  bit_cnt     <= 4'h0;
                  serial_buf  <= {shifter[6:0], sdat_s};
                  serial_flag <= 1'b1;
               end else
                  bit_cnt <= bit_cnt + 4'h1;
            end
         end else if (!tx_active) begin
            bit_cnt <= 4'h0;
            tx_clk  <= 1'b1;
            // a byte written in the loading cycle waits for the next underflow,
            // so the shifter never takes the stale buffer
            if (buf_pending && timer_a_uf && !ser_wr) begin
               shifter     <= serial_buf;
               buf_pending <= 1'b0;
               tx_active   <= 1'b1;
            end
         end else if (timer_a_uf) begin
            // each underflow is a half bit: one bit per two underflows
            if (tx_clk) begin
               tx_clk  <= 1'b0;
               tx_data <= shifter[7];
               shifter <= {shifter[6:0], 1'b0};
            end else begin
               tx_clk <= 1'b1;
               if (bit_cnt == `TSIU_BIT_COUNT - 4'h1) begin
                  serial_flag <= 1'b1;
                  bit_cnt     <= 4'h0;
                  if (buf_pending && !ser_wr) begin
                     shifter     <= serial_buf;
                     buf_pending <= 1'b0;
                  end else
                     tx_active <= buf_pending;
               end else
                  bit_cnt <= bit_cnt + 4'h1;
            end
         end
      end
   end

   // read mux; reads of the counter show the latched copy, never the alarm
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite) begin
         prdata <= 32'h00000000;
         if (is_idx(paddr, `TSIU_IDX_CNT_LOW))  prdata[7:0] <= read_copy[7:0];
         if (is_idx(paddr, `TSIU_IDX_CNT_MID))  prdata[7:0] <= read_copy[15:8];
         if (is_idx(paddr, `TSIU_IDX_CNT_HIGH)) prdata[7:0] <= read_copy[23:16];
         if (is_idx(paddr, `TSIU_IDX_CTRL))     prdata[1:0] <= ctrl;
         if (is_idx(paddr, `TSIU_IDX_TIMER_CTL)) prdata[16:0] <= timer_ctl;
         if (is_idx(paddr, `TSIU_IDX_SERIAL))   prdata[7:0] <= serial_buf;
         if (is_idx(paddr, `TSIU_IDX_IRQ))
            prdata[7:0] <= {request_summary_bit, 2'b00, flags};
      end
   end
endmodule // tsiu_top

// file: tsiu_chk.sv
/* port assertions for tsiu_top.
   assumes apb byte address = 4 * index. */
module tsiu_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        shift_clock_pin_out,
   input wire        shift_clock_pin_oe,
   input wire        serial_data_pin_out,
   input wire        serial_data_pin_oe,
   input wire        irq_n
);
   logic       tx;
   logic [4:0] msk;
   wire        wr = psel && penable && pwrite;
   wire        rd = psel && penable && !pwrite && paddr == 32'h34;
   // mirrors direction and mask state the ports never show
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx <= 1'b0;
         msk <= 5'h00;
      end else if (wr && paddr == 32'h2c) begin
         tx <= pwdata[0];
      end else if (wr && paddr == 32'h34) begin
         msk <= pwdata[7] ? (msk | pwdata[4:0]) : (msk & ~pwdata[4:0]);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   answer_ok_a: assert property (pready && !pslverr) else $error("bad apb answer");
   reset_out_a: assert property (disable iff (presetn) irq_n && !shift_clock_pin_oe
      && !serial_data_pin_oe && prdata == 32'h0) else $error("bad reset outputs");
   open_drain_a: assert property (!shift_clock_pin_out && !serial_data_pin_out)
      else $error("pin driven high");
   rx_quiet_a: assert property (!tx |-> !shift_clock_pin_oe && !serial_data_pin_oe)
      else $error("pin driven in receive");
   bit_edge_a: assert property (tx && $changed(serial_data_pin_oe)
      |-> $rose(shift_clock_pin_oe)) else $error("bit moved off falling clock");
   summary_a: assert property (rd |-> prdata[7] == !$past(irq_n))
      else $error("summary bit differs from request");
   pad_zero_a: assert property (rd |-> prdata[6:5] == 2'b00)
      else $error("flag bits 6:5 not zero");
   mask_need_a: assert property (!irq_n |-> msk != 5'h00)
      else $error("request with empty mask");
endmodule // tsiu_chk
bind tsiu_top tsiu_chk tsiu_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .shift_clock_pin_out(shift_clock_pin_out),
   .shift_clock_pin_oe(shift_clock_pin_oe), .serial_data_pin_out(serial_data_pin_out),
   .serial_data_pin_oe(serial_data_pin_oe), .irq_n(irq_n));

// file: tsiu_peer.sv
/* serial peer: clocks a byte in, or records bits sent out.
   assumes open-drain lines with pull-ups. */
module tsiu_peer (
   input  wire  sck,
   input  wire  sda,
   output logic clk_oe,
   output logic dat_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic listen = 1'b0;
   logic q[$];
   time  t0, t1;
   initial begin
      clk_oe = 1'b0;
      dat_oe = 1'b0;
   end
   // clock stands high between frames, 160 ns period inside
   task automatic send(input logic [7:0] b);
      #3;
      for (int i = 7; i >= 0; i--) begin
         clk_oe = 1'b1;
         dat_oe = !b[i];
         #80;
         clk_oe = 1'b0;
         #80;
      end
      dat_oe = 1'b0;
   endtask
   always @(posedge sck) begin
      if (listen) begin
         q.push_back(sda);
         if (q.size() == 1) t0 = $time;
         t1 = $time;
      end
   end
endmodule // tsiu_peer

// file: tb_tsiu_top.sv
/* bench for tsiu_top: apb master, expected values, serial peer.
   assumes the checker is bound in. */
module tb_tsiu_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, r;
   logic        ev_in = 0, fl_in = 1, tbu = 0;
   logic [7:0]  b1, b2, g1, g2;
   wire  [31:0] prdata;
   wire         pready, pslverr, ck_o, ck_oe, d_o, d_oe, irq_n, p_ck, p_d;
   wire         sck = !(ck_oe || p_ck);
   wire         sda = !(d_oe || p_d);
   int          fail_count = 0, tests_run = 0, cyc = 0;
   always #5 pclk = !pclk;
   tsiu_top tsiu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_pin(ev_in), .edge_pin_flag_in(fl_in),
      .timer_b_underflow(tbu), .shift_clock_pin_in(sck), .shift_clock_pin_out(ck_o),
      .shift_clock_pin_oe(ck_oe), .serial_data_pin_in(sda), .serial_data_pin_out(d_o),
      .serial_data_pin_oe(d_oe), .irq_n(irq_n));
   tsiu_peer tsiu_peer_inst (.sck(sck), .sda(sda), .clk_oe(p_ck), .dat_oe(p_d));
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(0, a, 0);
      chk(r[7:0], e);
   endtask
   // events are slow enough for the two-stage synchroniser
   task automatic ev(input int n);
      repeat (n) begin
         ev_in <= 1;
         repeat (4) @(posedge pclk);
         ev_in <= 0;
         repeat (4) @(posedge pclk);
      end
   endtask
   initial begin
      void'($urandom(32'hc42f));
      b1 = $urandom;
      b2 = $urandom;
      repeat (12) @(posedge pclk);
      presetn <= 1;
      repeat (3) @(posedge pclk);
      rd(8'h34, 8'h00);
      apb(1, 8'h2c, 2);
      apb(1, 8'h28, 8'h12);
      apb(1, 8'h24, 8'h34);
      apb(1, 8'h20, 8'h5a);
      apb(1, 8'h2c, 0);
      apb(1, 8'h28, 8'h12);
      apb(1, 8'h24, 8'h34);
      ev(2);
      apb(1, 8'h20, 8'h56);
      apb(1, 8'h34, 8'h84);
      rd(8'h20, 8'h56);
      ev(2);
      rd(8'h28, 8'h12);
      ev(1);
      rd(8'h24, 8'h34);
      rd(8'h20, 8'h58);
      rd(8'h20, 8'h59);
      chk(irq_n, 1);
      ev(1);
      chk(irq_n, 0);
      rd(8'h34, 8'h84);
      #1 chk(irq_n, 1);
      @(posedge pclk);
      fl_in <= 0;
      tbu <= 1;
      @(posedge pclk);
      tbu <= 0;
      apb(1, 8'h34, 8'h82);
      #1 chk(irq_n, 0);
      apb(1, 8'h34, 8'h06);
      #1 chk(irq_n, 1);
      rd(8'h34, 8'h12);
      rd(8'h34, 8'h00);
      tsiu_peer_inst.send(b1);
      repeat (8) @(posedge pclk);
      rd(8'h30, b1);
      rd(8'h34, 8'h08);
      apb(1, 8'h38, 32'h10003);
      apb(1, 8'h2c, 1);
      tsiu_peer_inst.listen = 1;
      apb(1, 8'h30, b1);
      while (ck_oe !== 1'b1) @(posedge pclk);
      apb(1, 8'h30, b2);
      while (tsiu_peer_inst.q.size() < 16) @(posedge pclk);
      repeat (24) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         g1 = {g1[6:0], tsiu_peer_inst.q[i]};
         g2 = {g2[6:0], tsiu_peer_inst.q[i + 8]};
      end
      chk(g1, b1);
      chk(g2, b2);
      chk(tsiu_peer_inst.t1 - tsiu_peer_inst.t0, 1200);
      chk({sck, sda}, {1'b1, b2[0]});
      apb(0, 8'h34, 0);
      chk(r[3], 1);
      conclude();
   end
endmodule // tb_tsiu_top
